/* ucr_pkg.sv */
// Constants and types for the control request decoder
// Overview of operation
// - Vendor read: type c0, code 05
// - Read returns exactly length bytes from offset
// - Vendor write: type 40, code 05, stores bytes
// - Set address adopts value field address
// - Clear feature index 00 clears control halt
// - Clear feature 81, 02, 83 clears halts
// - Set feature halts bulk and interrupt endpoints
// - Set interface zero, alternate zero accepted
// - Device set feature 01 enables wake-up
// - Device clear feature 01 disables wake-up
package ucr_pkg;

  // ==========================================================
  // Setup packet field positions (byte lanes of 64-bit word)
  // ==========================================================
  localparam int unsigned TYPE_LSB   = 0;
  localparam int unsigned CODE_LSB   = 8;
  localparam int unsigned VALUE_LSB  = 16;
  localparam int unsigned INDEX_LSB  = 32;
  localparam int unsigned LENGTH_LSB = 48;

  // ==========================================================
  // Request types and codes
  // ==========================================================
  localparam logic [7:0] TYPE_VEND_IN   = 8'hc0;
  localparam logic [7:0] TYPE_VEND_OUT  = 8'h40;
  localparam logic [7:0] TYPE_DEVICE    = 8'h00;
  localparam logic [7:0] TYPE_INTERFACE = 8'h01;
  localparam logic [7:0] TYPE_ENDPOINT  = 8'h02;
  localparam logic [7:0] CODE_VEND_REG  = 8'h05;
  localparam logic [7:0] CODE_SET_ADDR  = 8'h05;
  localparam logic [7:0] CODE_CLR_FEAT  = 8'h01;
  localparam logic [7:0] CODE_SET_FEAT  = 8'h03;
  localparam logic [7:0] CODE_SET_IFACE = 8'h0b;
  localparam logic [15:0] FEAT_WAKEUP   = 16'h0001;

  // ==========================================================
  // Endpoint index values and halt bit positions
  // ==========================================================
  localparam logic [15:0] IDX_CONTROL   = 16'h0000;
  localparam logic [15:0] IDX_BULK_IN   = 16'h0081;
  localparam logic [15:0] IDX_BULK_OUT  = 16'h0002;
  localparam logic [15:0] IDX_INTR_IN   = 16'h0083;
  localparam logic [15:0] IDX_INTR_IN_H = 16'h8300;
  localparam logic [1:0]  EP_CONTROL    = 2'h0;
  localparam logic [1:0]  EP_BULK_IN    = 2'h1;
  localparam logic [1:0]  EP_BULK_OUT   = 2'h2;
  localparam logic [1:0]  EP_INTR_IN    = 2'h3;

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [6:0]  ADDR_RESET   = 7'h00;
  localparam logic [3:0]  HALT_RESET   = 4'h0;
  localparam logic [15:0] ZERO16       = 16'h0000;
  localparam logic [15:0] ONE16        = 16'h0001;

  // Decoded request kinds
  typedef enum logic [3:0] {
    CMD_UNKNOWN   = 4'b0000,
    CMD_REG_READ  = 4'b0001,
    CMD_REG_WRITE = 4'b0010,
    CMD_SET_ADDR  = 4'b0011,
    CMD_EP_CLEAR  = 4'b0100,
    CMD_EP_SET    = 4'b0101,
    CMD_SET_IFACE = 4'b0110,
    CMD_WAKE_SET  = 4'b0111,
    CMD_WAKE_CLR  = 4'b1000
  } ucr_cmd_e;

  // Data stage sequencer states
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_RD_STRB = 3'b001,
    ST_RD_CAPT = 3'b010,
    ST_RD_SEND = 3'b011,
    ST_WR_WAIT = 3'b100
  } ucr_state_e;

endpackage

/* ucr_setup_if.sv */
// Carrier between setup decoder and request sequencer
interface ucr_setup_if;
  logic             setup_valid;
  logic [63:0]      setup_word;
  logic             dec_valid;
  ucr_pkg::ucr_cmd_e dec_cmd;
  logic [15:0]      dec_value;
  logic [15:0]      dec_length;
  logic [1:0]       dec_ep;

  modport decoder (
    input  setup_valid, setup_word,
    output dec_valid, dec_cmd, dec_value, dec_length, dec_ep
  );
  modport sequencer (
    output setup_valid, setup_word,
    input  dec_valid, dec_cmd, dec_value, dec_length, dec_ep
  );
endinterface

/* ucr_setup_decoder.sv */
// Setup packet classifier with registered result
module ucr_setup_decoder (
  // Clock, reset, enable
  input  wire logic     ref_clk_in,
  input  wire logic     rst_n_in,
  input  wire logic     ce_in,
  // Setup packet and decoded request
  ucr_setup_if.decoder  sif
);

  // ==========================================================
  // Field extraction
  // ==========================================================
  logic [7:0]  req_type;
  logic [7:0]  req_code;
  logic [15:0] req_value;
  logic [15:0] req_index;
  logic [15:0] req_length;
  logic        no_data;

  assign req_type   = sif.setup_word[ucr_pkg::TYPE_LSB +: 8];
  assign req_code   = sif.setup_word[ucr_pkg::CODE_LSB +: 8];
  assign req_value  = sif.setup_word[ucr_pkg::VALUE_LSB +: 16];
  assign req_index  = sif.setup_word[ucr_pkg::INDEX_LSB +: 16];
  assign req_length = sif.setup_word[ucr_pkg::LENGTH_LSB +: 16];
  assign no_data    = (req_length == ucr_pkg::ZERO16);

  // Endpoint index to halt bit; bit 2 flags an unknown index
  function automatic logic [2:0] ep_sel(input logic [15:0] idx);
    unique case (idx)
      ucr_pkg::IDX_CONTROL:   ep_sel = {1'b0, ucr_pkg::EP_CONTROL};
      ucr_pkg::IDX_BULK_IN:   ep_sel = {1'b0, ucr_pkg::EP_BULK_IN};
      ucr_pkg::IDX_BULK_OUT:  ep_sel = {1'b0, ucr_pkg::EP_BULK_OUT};
      ucr_pkg::IDX_INTR_IN,
      ucr_pkg::IDX_INTR_IN_H: ep_sel = {1'b0, ucr_pkg::EP_INTR_IN};
      default:                ep_sel = 3'h4;
    endcase
  endfunction

  logic [2:0]        ep_hit;
  ucr_pkg::ucr_cmd_e cmd_d;

  assign ep_hit = ep_sel(req_index);

  // Classify the request
  always_comb begin
    cmd_d = ucr_pkg::CMD_UNKNOWN;
    if (req_type == ucr_pkg::TYPE_VEND_IN &&
        req_code == ucr_pkg::CODE_VEND_REG &&
        req_index == ucr_pkg::ZERO16) begin
      cmd_d = ucr_pkg::CMD_REG_READ;
    end
    else if (req_type == ucr_pkg::TYPE_VEND_OUT &&
             req_code == ucr_pkg::CODE_VEND_REG &&
             req_index == ucr_pkg::ZERO16) begin
      cmd_d = ucr_pkg::CMD_REG_WRITE;
    end
    else if (no_data && req_type == ucr_pkg::TYPE_DEVICE &&
             req_index == ucr_pkg::ZERO16) begin
      if (req_code == ucr_pkg::CODE_SET_ADDR && !req_value[7] &&
          req_value[15:8] == 8'h00) begin
        cmd_d = ucr_pkg::CMD_SET_ADDR;
      end
      else if (req_code == ucr_pkg::CODE_SET_FEAT &&
               req_value == ucr_pkg::FEAT_WAKEUP) begin
        cmd_d = ucr_pkg::CMD_WAKE_SET;
      end
      else if (req_code == ucr_pkg::CODE_CLR_FEAT &&
               req_value == ucr_pkg::FEAT_WAKEUP) begin
        cmd_d = ucr_pkg::CMD_WAKE_CLR;
      end
    end
    else if (no_data && req_type == ucr_pkg::TYPE_ENDPOINT &&
             req_value == ucr_pkg::ZERO16 && !ep_hit[2]) begin
      if (req_code == ucr_pkg::CODE_CLR_FEAT) begin
        cmd_d = ucr_pkg::CMD_EP_CLEAR;
      end
      else if (req_code == ucr_pkg::CODE_SET_FEAT &&
               ep_hit[1:0] != ucr_pkg::EP_CONTROL) begin
        cmd_d = ucr_pkg::CMD_EP_SET;
      end
    end
    else if (no_data && req_type == ucr_pkg::TYPE_INTERFACE &&
             req_code == ucr_pkg::CODE_SET_IFACE &&
             req_value == ucr_pkg::ZERO16 &&
             req_index == ucr_pkg::ZERO16) begin
      cmd_d = ucr_pkg::CMD_SET_IFACE;
    end
  end

  // Register the decoded request
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      sif.dec_valid  <= 1'b0;
      sif.dec_cmd    <= ucr_pkg::CMD_UNKNOWN;
      sif.dec_value  <= ucr_pkg::ZERO16;
      sif.dec_length <= ucr_pkg::ZERO16;
      sif.dec_ep     <= ucr_pkg::EP_CONTROL;
    end else if (ce_in) begin
      sif.dec_valid  <= sif.setup_valid;
      if (sif.setup_valid) begin
        sif.dec_cmd    <= cmd_d;
        sif.dec_value  <= req_value;
        sif.dec_length <= req_length;
        sif.dec_ep     <= ep_hit[1:0];
      end
    end
  end

endmodule

/* ucr_request_decoder.sv */
// Control endpoint request sequencer and register access
module ucr_request_decoder (
  // Clock, reset, enable
  input  wire logic        ref_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        ce_in,
  // Setup packet from the usb serial engine
  input  wire logic        setup_valid_in,
  input  wire logic [63:0] setup_in,
  // Data stage, device to host
  output logic             in_valid_out,
  output logic [7:0]       in_data_out,
  input  wire logic        in_ready_in,
  // Data stage, host to device
  input  wire logic        out_valid_in,
  input  wire logic [7:0]  out_data_in,
  output logic             out_ready_out,
  // Request outcome
  output logic             done_out,
  output logic             stall_out,
  // Internal register space
  output logic             reg_rd_out,
  output logic             reg_wr_out,
  output logic [15:0]      reg_addr_out,
  output logic [7:0]       reg_wdata_out,
  input  wire logic [7:0]  reg_rdata_in,
  // Device state
  output logic [6:0]       device_address_out,
  output logic [3:0]       ep_halt_out,
  output logic             remote_wakeup_out,
  output logic             iface_set_out
);

  // ==========================================================
  // Decoder instance
  // ==========================================================
  ucr_setup_if sif ();

  assign sif.setup_valid = setup_valid_in;
  assign sif.setup_word  = setup_in;

  ucr_setup_decoder u_dec (
    .ref_clk_in (ref_clk_in),
    .rst_n_in   (rst_n_in),
    .ce_in      (ce_in),
    .sif        (sif)
  );

  // ==========================================================
  // Sequencer state
  // ==========================================================
  ucr_pkg::ucr_state_e state_q;
  logic [15:0]         ptr_q;       // Next register offset
  logic [15:0]         left_q;      // Bytes still to move
  logic                new_rd;
  logic                new_wr;
  logic                last_byte;

  assign new_rd    = sif.dec_valid &&
                     sif.dec_cmd == ucr_pkg::CMD_REG_READ;
  assign new_wr    = sif.dec_valid &&
                     sif.dec_cmd == ucr_pkg::CMD_REG_WRITE;
  assign last_byte = (left_q == ucr_pkg::ONE16);

  // State, pointer and byte count; a new setup aborts any transfer
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      state_q <= ucr_pkg::ST_IDLE;
      ptr_q   <= ucr_pkg::ZERO16;
      left_q  <= ucr_pkg::ZERO16;
    end else if (ce_in) begin
      if (new_rd || new_wr) begin
        ptr_q  <= sif.dec_value;
        left_q <= sif.dec_length;
        if (sif.dec_length == ucr_pkg::ZERO16) begin
          state_q <= ucr_pkg::ST_IDLE;
        end else if (new_rd) begin
          state_q <= ucr_pkg::ST_RD_STRB;
        end else begin
          state_q <= ucr_pkg::ST_WR_WAIT;
        end
      end else if (sif.dec_valid) begin
        state_q <= ucr_pkg::ST_IDLE;
      end else begin
        unique case (state_q)
          ucr_pkg::ST_IDLE: begin
            state_q <= ucr_pkg::ST_IDLE;
          end
          ucr_pkg::ST_RD_STRB: begin
            state_q <= ucr_pkg::ST_RD_CAPT;
          end
          ucr_pkg::ST_RD_CAPT: begin
            state_q <= ucr_pkg::ST_RD_SEND;
          end
          ucr_pkg::ST_RD_SEND: begin
            if (in_ready_in) begin
              ptr_q   <= ptr_q + ucr_pkg::ONE16;
              left_q  <= left_q - ucr_pkg::ONE16;
              state_q <= last_byte ? ucr_pkg::ST_IDLE
                                   : ucr_pkg::ST_RD_STRB;
            end
          end
          ucr_pkg::ST_WR_WAIT: begin
            if (out_valid_in) begin
              ptr_q   <= ptr_q + ucr_pkg::ONE16;
              left_q  <= left_q - ucr_pkg::ONE16;
              state_q <= last_byte ? ucr_pkg::ST_IDLE
                                   : ucr_pkg::ST_WR_WAIT;
            end
          end
          default: begin
            state_q <= ucr_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Register space strobes
  // ==========================================================
  // read strobes walk consecutive offsets
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      reg_rd_out    <= 1'b0;
      reg_wr_out    <= 1'b0;
      reg_addr_out  <= ucr_pkg::ZERO16;
      reg_wdata_out <= 8'h00;
    end else if (ce_in) begin
      reg_rd_out <= 1'b0;
      reg_wr_out <= 1'b0;
      if (new_rd && sif.dec_length != ucr_pkg::ZERO16) begin
        reg_rd_out   <= 1'b1;
        reg_addr_out <= sif.dec_value;
      end else if (!sif.dec_valid &&
                   state_q == ucr_pkg::ST_RD_SEND &&
                   in_ready_in && !last_byte) begin
        reg_rd_out   <= 1'b1;
        reg_addr_out <= ptr_q + ucr_pkg::ONE16;
      end else if (!sif.dec_valid &&
                   state_q == ucr_pkg::ST_WR_WAIT && out_valid_in) begin
        // word pairs arrive as two byte writes
        reg_wr_out    <= 1'b1;
        reg_addr_out  <= ptr_q;
        reg_wdata_out <= out_data_in;
      end
    end
  end

  // ==========================================================
  // Data stage handshakes
  // ==========================================================
  // Present one read byte, accept host bytes while writing
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      in_valid_out  <= 1'b0;
      in_data_out   <= 8'h00;
      out_ready_out <= 1'b0;
    end else if (ce_in) begin
      if (sif.dec_valid) begin
        in_valid_out  <= 1'b0;
        out_ready_out <= new_wr && sif.dec_length != ucr_pkg::ZERO16;
      end else begin
        if (state_q == ucr_pkg::ST_RD_CAPT) begin
          in_valid_out <= 1'b1;
          in_data_out  <= reg_rdata_in;
        end else if (state_q == ucr_pkg::ST_RD_SEND && in_ready_in) begin
          in_valid_out <= 1'b0;
        end
        if (state_q == ucr_pkg::ST_WR_WAIT && out_valid_in && last_byte)
        begin
          out_ready_out <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // Outcome pulses
  // ==========================================================
  // Done on completion, stall on an unknown request
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      done_out  <= 1'b0;
      stall_out <= 1'b0;
    end else if (ce_in) begin
      done_out  <= 1'b0;
      stall_out <= 1'b0;
      if (sif.dec_valid) begin
        stall_out <= (sif.dec_cmd == ucr_pkg::CMD_UNKNOWN);
        done_out  <= (sif.dec_cmd != ucr_pkg::CMD_UNKNOWN) &&
                     ((!new_rd && !new_wr) ||
                      sif.dec_length == ucr_pkg::ZERO16);
      end else if (last_byte &&
                   ((state_q == ucr_pkg::ST_RD_SEND && in_ready_in) ||
                    (state_q == ucr_pkg::ST_WR_WAIT && out_valid_in)))
      begin
        done_out <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Device state updates
  // ==========================================================
  // Address, halts, wake-up and interface selection
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      device_address_out <= ucr_pkg::ADDR_RESET;
      ep_halt_out        <= ucr_pkg::HALT_RESET;
      remote_wakeup_out  <= 1'b0;
      iface_set_out      <= 1'b0;
    end else if (ce_in && sif.dec_valid) begin
      unique case (sif.dec_cmd)
        ucr_pkg::CMD_SET_ADDR: begin
          device_address_out <= sif.dec_value[6:0];
        end
        ucr_pkg::CMD_EP_CLEAR: begin
          ep_halt_out[sif.dec_ep] <= 1'b0;
        end
        ucr_pkg::CMD_EP_SET: begin
          ep_halt_out[sif.dec_ep] <= 1'b1;
        end
        ucr_pkg::CMD_SET_IFACE: begin
          iface_set_out <= 1'b1;
        end
        ucr_pkg::CMD_WAKE_SET: begin
          remote_wakeup_out <= 1'b1;
        end
        ucr_pkg::CMD_WAKE_CLR: begin
          remote_wakeup_out <= 1'b0;
        end
        default: begin
          iface_set_out <= iface_set_out;
        end
      endcase
    end
  end

endmodule

/* ucr_request_monitor.sv */
// Assertion checker for the control request decoder
module ucr_request_monitor (
  // Clock and reset
  input wire logic        ref_clk_in,
  input wire logic        rst_n_in,
  // Setup and data stages
  input wire logic        setup_valid_in,
  input wire logic [63:0] setup_in,
  input wire logic        in_valid_out,
  input wire logic        in_ready_in,
  input wire logic        out_valid_in,
  input wire logic [7:0]  out_data_in,
  input wire logic        out_ready_out,
  // Outcome and device state
  input wire logic        done_out,
  input wire logic        stall_out,
  input wire logic        reg_rd_out,
  input wire logic        reg_wr_out,
  input wire logic [15:0] reg_addr_out,
  input wire logic [7:0]  reg_wdata_out,
  input wire logic [6:0]  device_address_out,
  input wire logic [3:0]  ep_halt_out,
  input wire logic        remote_wakeup_out,
  input wire logic        iface_set_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);

  // ==========================================================
  // Read progress tracking
  // ==========================================================
  logic        rd_act_q;
  logic [15:0] rd_len_q;
  logic [15:0] rd_cnt_q;

  // A read is open from its setup until done or stall
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in)
      rd_act_q <= 1'b0;
    else if (setup_valid_in)
      rd_act_q <= (setup_in[15:0] == 16'h05c0);
    else if (done_out || stall_out)
      rd_act_q <= 1'b0;
  end

  // Requested length of the latest setup
  always_ff @(posedge ref_clk_in) begin
    if (setup_valid_in)
      rd_len_q <= setup_in[63:48];
  end

  // Bytes taken by the host since the latest setup
  always_ff @(posedge ref_clk_in) begin
    if (setup_valid_in)
      rd_cnt_q <= 16'h0000;
    else if (in_valid_out && in_ready_in)
      rd_cnt_q <= rd_cnt_q + 16'h0001;
  end

  // ==========================================================
  // Request sequences
  // ==========================================================
  sequence s_req(w);
    setup_valid_in && setup_in == w ##1 !setup_valid_in;
  endsequence
  sequence s_addr;
    setup_valid_in && setup_in[15:0] == 16'h0500 &&
      setup_in[63:23] == '0 ##1 !setup_valid_in;
  endsequence
  sequence s_odd;
    setup_valid_in &&
      !(setup_in[7:0] inside {8'hc0, 8'h40, 8'h00, 8'h01, 8'h02})
      ##1 !setup_valid_in;
  endsequence
  sequence s_read;
    setup_valid_in && setup_in[15:0] == 16'h05c0 &&
      setup_in[63:48] != 16'h0000 ##1 !setup_valid_in;
  endsequence

  // ==========================================================
  // Assertions
  // ==========================================================
  addr_adopt_a:
  assert property (s_addr |-> ##1 done_out &&
    device_address_out == $past(setup_in[22:16], 2))
    else $error("set address not adopted");
  halt_set_a:
  assert property (s_req(64'h0000_0081_0000_0302) |-> ##1
    done_out && ep_halt_out[1]) else $error("bulk in not halted");
  halt_clear_a:
  assert property (s_req(64'h0000_0083_0000_0102) |-> ##1
    done_out && !ep_halt_out[3]) else $error("intr halt not cleared");
  ctrl_clear_a:
  assert property (s_req(64'h0000_0000_0000_0102) |-> ##1
    done_out && !ep_halt_out[0]) else $error("ctrl halt not cleared");
  wake_set_a:
  assert property (s_req(64'h0000_0000_0001_0300) |-> ##1
    done_out && remote_wakeup_out) else $error("wakeup not enabled");
  wake_clear_a:
  assert property (s_req(64'h0000_0000_0001_0100) |-> ##1
    done_out && !remote_wakeup_out) else $error("wakeup not disabled");
  iface_sel_a:
  assert property (s_req(64'h0000_0000_0000_0b01) |-> ##1
    done_out && iface_set_out) else $error("interface not accepted");
  unknown_stall_a:
  assert property (s_odd |-> ##1 stall_out && !done_out &&
    ep_halt_out == $past(ep_halt_out, 2) &&
    device_address_out == $past(device_address_out, 2))
    else $error("unknown request not stalled");
  read_fetch_a:
  assert property (s_read |-> ##1 reg_rd_out &&
    reg_addr_out == $past(setup_in[31:16], 2))
    else $error("read not started at offset");
  read_count_a:
  assert property (rd_act_q && done_out |-> rd_cnt_q == rd_len_q)
    else $error("read byte count wrong");
  offer_hold_a:
  assert property (in_valid_out && !in_ready_in && !setup_valid_in
    && !$past(setup_valid_in) |=> in_valid_out)
    else $error("read byte withdrawn");
  write_store_a:
  assert property (out_valid_in && out_ready_out && !setup_valid_in
    |=> reg_wr_out && reg_wdata_out == $past(out_data_in))
    else $error("host byte not stored");
endmodule

bind ucr_request_decoder ucr_request_monitor u_ucr_request_monitor (
  .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
  .setup_valid_in(setup_valid_in), .setup_in(setup_in),
  .in_valid_out(in_valid_out), .in_ready_in(in_ready_in),
  .out_valid_in(out_valid_in), .out_data_in(out_data_in),
  .out_ready_out(out_ready_out), .done_out(done_out),
  .stall_out(stall_out), .reg_rd_out(reg_rd_out),
  .reg_wr_out(reg_wr_out), .reg_addr_out(reg_addr_out),
  .reg_wdata_out(reg_wdata_out),
  .device_address_out(device_address_out),
  .ep_halt_out(ep_halt_out), .remote_wakeup_out(remote_wakeup_out),
  .iface_set_out(iface_set_out));

/* ucr_host_model.sv */
// Behavioural serial engine side of the control data stages
module ucr_host_model (
  // Clock
  input  wire logic       clk_in,
  // Device to host bytes
  input  wire logic       in_valid_in,
  input  wire logic [7:0] in_data_in,
  output logic            in_ready_out,
  // Host to device bytes
  output logic            out_valid_out,
  output logic [7:0]      out_data_out,
  input  wire logic       out_ready_in,
  // Idle cycles before taking a byte
  input  wire logic [3:0] slow_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] rx_q[$];
  logic [7:0] tx_q[$];
  int         wait_cnt = 0;

  initial begin
    in_ready_out = 1'b0;
    out_valid_out = 1'b0;
    out_data_out = 8'h00;
  end

  always @(posedge clk_in) begin
    if (in_valid_in && in_ready_out)
      rx_q.push_back(in_data_in);
    if (out_valid_out && out_ready_in)
      void'(tx_q.pop_front());
    #1;
    if (in_ready_out) begin
      in_ready_out = 1'b0;
      wait_cnt = 0;
    end else if (in_valid_in) begin
      if (wait_cnt >= int'(slow_in))
        in_ready_out = 1'b1;
      else
        wait_cnt++;
    end else
      wait_cnt = 0;
    // Released data line never keeps its last value
    out_valid_out = tx_q.size() > 0;
    out_data_out = out_valid_out ? tx_q[0] : ~out_data_out;
  end
endmodule

/* test_usb_control_request_decoder.sv */
// Self-checking bench for the control request decoder
module test_usb_control_request_decoder;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    logic [63:0] w;
    logic        st;
    logic [6:0]  adr;
    logic [3:0]  hlt;
    logic        wk;
    logic        ifc;
  } ucr_row_s;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        sv = 1'b0;
  logic [63:0] sw = 64'h0;
  logic [7:0]  rdata = 8'h00;
  logic [3:0]  slow = 4'h0;
  logic        in_valid, in_ready, out_valid, out_ready, done, stall;
  logic        rd, wr, wake, ifc, got_d, got_s;
  logic [7:0]  in_data, out_data, wdata;
  logic [15:0] addr;
  logic [6:0]  dev_addr;
  logic [3:0]  halt;
  logic [7:0]  mem [256];
  logic [23:0] wr_log[$];
  logic [15:0] rd_log[$];
  logic [7:0]  exp_b [3] = '{8'h11, 8'h22, 8'h58};
  int          mismatches = 0, comparisons = 0, cycles = 0;
  ucr_row_s    rows [15] = '{
    '{64'h0000_0000_007f_0500, 0, 7'h7f, 4'h0, 0, 0},
    '{64'h0000_0081_0000_0302, 0, 7'h7f, 4'h2, 0, 0},
    '{64'h0000_0002_0000_0302, 0, 7'h7f, 4'h6, 0, 0},
    '{64'h0000_8300_0000_0302, 0, 7'h7f, 4'he, 0, 0},
    '{64'h0000_0000_0001_0300, 0, 7'h7f, 4'he, 1, 0},
    '{64'h0000_0000_0000_0b01, 0, 7'h7f, 4'he, 1, 1},
    '{64'h0000_0000_0003_0523, 1, 7'h7f, 4'he, 1, 1},
    '{64'h0000_0000_0000_06c0, 1, 7'h7f, 4'he, 1, 1},
    '{64'h0000_0000_0000_0302, 1, 7'h7f, 4'he, 1, 1},
    '{64'h0000_0000_0001_0100, 0, 7'h7f, 4'he, 0, 1},
    '{64'h0000_0081_0000_0102, 0, 7'h7f, 4'hc, 0, 1},
    '{64'h0000_0002_0000_0102, 0, 7'h7f, 4'h8, 0, 1},
    '{64'h0000_0083_0000_0102, 0, 7'h7f, 4'h0, 0, 1},
    '{64'h0000_0000_0000_0102, 0, 7'h7f, 4'h0, 0, 1},
    '{64'h0000_0000_0000_0500, 0, 7'h00, 4'h0, 0, 1}};

  always #5 clk = ~clk;

  ucr_request_decoder u_ucr_request_decoder (
    .ref_clk_in(clk), .rst_n_in(rst_n), .ce_in(1'b1),
    .setup_valid_in(sv), .setup_in(sw),
    .in_valid_out(in_valid), .in_data_out(in_data),
    .in_ready_in(in_ready), .out_valid_in(out_valid),
    .out_data_in(out_data), .out_ready_out(out_ready),
    .done_out(done), .stall_out(stall), .reg_rd_out(rd),
    .reg_wr_out(wr), .reg_addr_out(addr), .reg_wdata_out(wdata),
    .reg_rdata_in(rdata), .device_address_out(dev_addr),
    .ep_halt_out(halt), .remote_wakeup_out(wake), .iface_set_out(ifc));
  ucr_host_model u_ucr_host_model (
    .clk_in(clk), .in_valid_in(in_valid), .in_data_in(in_data),
    .in_ready_out(in_ready), .out_valid_out(out_valid),
    .out_data_out(out_data), .out_ready_in(out_ready),
    .slow_in(slow));

  // Register space stand-in: data valid only the cycle after a strobe
  initial foreach (mem[i]) mem[i] = 8'(i) ^ 8'h5a;
  always @(posedge clk) begin
    if (wr) begin
      mem[addr[7:0]] = wdata;
      wr_log.push_back({addr, wdata});
    end
    if (rd)
      rd_log.push_back(addr);
    rdata <= #1 rd ? mem[addr[7:0]] : ~rdata;
  end

  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      complete_run();
    end
  end

  task automatic check(string nm, logic [23:0] seen, logic [23:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One setup pulse, data line scrambled afterwards
  task automatic send(logic [63:0] w);
    sv = 1'b1;
    sw = w;
    @(posedge clk);
    #1;
    sv = 1'b0;
    sw = ~w;
  endtask

  task automatic request(logic [63:0] w);
    send(w);
    got_d = 1'b0;
    got_s = 1'b0;
    for (int i = 0; i < 100 && !got_d && !got_s; i++) begin
      @(posedge clk);
      #1;
      got_d = done;
      got_s = stall;
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge clk);
    #1;
    rst_n = 1'b1;
    // Table of no-data requests, the first right after reset
    foreach (rows[i]) begin
      request(rows[i].w);
      check("stall", 24'(got_s), 24'(rows[i].st));
      check("done", 24'(got_d), 24'(!rows[i].st));
      check("addr", 24'(dev_addr), 24'(rows[i].adr));
      check("halt", 24'(halt), 24'(rows[i].hlt));
      check("wake", 24'(wake), 24'(rows[i].wk));
      check("iface", 24'(ifc), 24'(rows[i].ifc));
    end
    $display("test table done");
    // word area written as two byte writes
    u_ucr_host_model.tx_q = '{8'h11, 8'h22};
    request(64'h0002_0000_1200_0540);
    // Last byte store is logged one edge after done
    @(posedge clk);
    #1;
    check("wr done", 24'(got_d), 24'h1);
    check("wr n", 24'(wr_log.size()), 24'h2);
    check("wr0", wr_log[0], 24'h1200_11);
    check("wr1", wr_log[1], 24'h1201_22);
    $display("test write done");
    slow = 4'h3;
    request(64'h0003_0000_1200_05c0);
    check("rd done", 24'(got_d), 24'h1);
    check("rd n", 24'(u_ucr_host_model.rx_q.size()), 24'h3);
    for (int i = 0; i < 3; i++) begin
      check("rd byte", 24'(u_ucr_host_model.rx_q[i]), 24'(exp_b[i]));
      check("rd addr", 24'(rd_log[i]), 24'h1200 + 24'(i));
    end
    u_ucr_host_model.rx_q.delete();
    rd_log.delete();
    request(64'h0000_0000_0010_05c0);
    check("rd0 done", 24'(got_d), 24'h1);
    check("rd0 n", 24'(rd_log.size() + u_ucr_host_model.rx_q.size()),
      24'h0);
    $display("test read done");
    // Set address lands while a slow read is offering its first byte
    slow = 4'h8;
    send(64'h0004_0000_0040_05c0);
    repeat (5) @(posedge clk);
    #1;
    request(64'h0000_0000_0015_0500);
    check("ab done", 24'(got_d), 24'h1);
    check("ab addr", 24'(dev_addr), 24'h15);
    repeat (20) @(posedge clk);
    #1;
    check("ab n", 24'(u_ucr_host_model.rx_q.size()), 24'h0);
    check("ab offer", 24'(in_valid), 24'h0);
    $display("test abort done");
    rst_n = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    rst_n = 1'b1;
    check("reset", 24'({dev_addr, halt, wake, ifc, in_valid, out_ready,
      done, stall, rd, wr}), 24'h0);
    $display("test reset done");
    complete_run();
  end
endmodule
